/* aif_pkg.sv */
package aif_pkg;

  localparam int NUM_LINES = 4;
  localparam int RESULT_W = 12;

  // register byte addresses
  localparam logic [7:0] ADDR_FLAG = 8'h00;
  localparam logic [7:0] ADDR_CLEAR = 8'h04;
  localparam logic [7:0] ADDR_OVF = 8'h08;
  localparam logic [7:0] ADDR_OVF_CLEAR = 8'h0C;
  localparam logic [7:0] ADDR_CONT = 8'h10;
  localparam logic [7:0] ADDR_CTRL = 8'h14;
  localparam logic [7:0] ADDR_RESULT = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;

  // control register fields
  localparam int CTRL_LATE_BIT = 0;
  localparam int CTRL_DIV_LSB = 4;
  localparam int DIV_W = 4;

  // in late mode the flag leads the result latch by 3 cycles, not 1, when the divider is above this
  localparam logic [DIV_W-1:0] DIV_LEAD_LIMIT = 4'h2;
  localparam logic [DIV_W-1:0] LEAD_CYCLES = 4'h3;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic valid;
    logic [1:0] line;
    logic [RESULT_W-1:0] data;
  } aif_conv_t;

  typedef struct packed {
    logic sel;
    logic write;
    logic [7:0] addr;
  } aif_bus_req_t;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [31:0] wdata;
  } aif_reg_wr_t;

endpackage : aif_pkg

/* aif_ahb_slave.sv */
`timescale 1ns/1ns
module aif_ahb_slave
  import aif_pkg::*;
(
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  output aif_reg_wr_t wr_out,
  output aif_bus_req_t rd_out
);

  typedef struct packed {
    aif_bus_req_t ph;
  } aif_ahb_state_t;

  aif_ahb_state_t st;
  aif_ahb_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.ph.sel = 1'b0;
    if (hready_in) begin
      next_st.ph.sel = hsel_in && htrans_in == HTRANS_NONSEQ && hsize_in == HSIZE_WORD;
      next_st.ph.write = hwrite_in;
      next_st.ph.addr = haddr_in[7:0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // data phase: write lands with hwdata, read request passed on for decode
  always_comb begin
    wr_out.we = st.ph.sel && st.ph.write;
    wr_out.addr = st.ph.addr;
    wr_out.wdata = hwdata_in;
    rd_out = st.ph;
  end

endmodule : aif_ahb_slave

/* aif_lead_delay.sv */
`timescale 1ns/1ns
module aif_lead_delay
  import aif_pkg::*;
(
  input wire logic clock_in,
  input wire logic srst_in,
  input aif_conv_t conv_in,
  input wire logic [DIV_W-1:0] hold_in,
  output aif_conv_t conv_out
);

  // holds one conversion for hold_in cycles, then presents it for one cycle
  typedef struct packed {
    aif_conv_t pend;
    logic [DIV_W-1:0] count;
  } aif_dly_state_t;

  aif_dly_state_t st;
  aif_dly_state_t next_st;

  always_comb begin
    next_st = st;
    conv_out = '0;
    if (st.pend.valid) begin
      if (st.count <= 4'h1) begin
        conv_out = st.pend;
        next_st.pend.valid = 1'b0;
      end else begin
        next_st.count = st.count - 4'h1;
      end
    end
    if (conv_in.valid) begin
      next_st.pend = conv_in;
      next_st.count = hold_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : aif_lead_delay

/* aif_irq_ctrl.sv */
// Chosen here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module aif_irq_ctrl
  import aif_pkg::*;
#(
  parameter int LINES = NUM_LINES
) (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  input aif_conv_t conv_in,
  output logic [LINES-1:0] conversion_irq_out,
  output logic [LINES-1:0] dma_trigger_out,
  output logic [LINES-1:0] accel_trigger_out,
  output logic [RESULT_W-1:0] conversion_result_out,
  output logic cpu_irq_out
);

  typedef struct packed {
    logic [LINES-1:0] conversion_irq_flag;
    logic [LINES-1:0] irq_overflow_flag;
    logic [LINES-1:0] continuous_irq_select;
    logic late_mode;
    logic [DIV_W-1:0] clock_divider_setting;
    logic [RESULT_W-1:0] conversion_result;
    logic [LINES-1:0] irq_pulse;
    logic [LINES-1:0] sts;
    logic [LINES-1:0] mask;
    logic cpu_irq;
    logic [31:0] rdata;
  } aif_state_t;

  aif_state_t st;
  aif_state_t next_st;
  aif_reg_wr_t wr;
  aif_bus_req_t rd;
  aif_conv_t latched;
  logic [DIV_W-1:0] hold;
  logic [LINES-1:0] event_vec;
  logic [LINES-1:0] clear_vec;
  logic [LINES-1:0] ovf_clear_vec;

  function automatic logic hit(input aif_reg_wr_t w, input logic [7:0] a);
    hit = w.we && w.addr == a;
  endfunction : hit

  aif_ahb_slave u_bus (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .hsel_in(hsel_in),
    .haddr_in(haddr_in),
    .htrans_in(htrans_in),
    .hwrite_in(hwrite_in),
    .hsize_in(hsize_in),
    .hready_in(hready_in),
    .hwdata_in(hwdata_in),
    .wr_out(wr),
    .rd_out(rd)
  );

  // result latch trails the flag by 3 cycles instead of 1 when late mode and divider above limit
  always_comb begin
    hold = 4'h1;
    if (st.late_mode && st.clock_divider_setting > DIV_LEAD_LIMIT) begin
      hold = LEAD_CYCLES;
    end
  end

  aif_lead_delay u_lead (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .conv_in(conv_in),
    .hold_in(hold),
    .conv_out(latched)
  );

  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : g_line
      assign event_vec[g] = conv_in.valid && conv_in.line == 2'(g);
    end
  endgenerate

  always_comb begin
    clear_vec = '0;
    ovf_clear_vec = '0;
    if (hit(wr, ADDR_CLEAR)) begin
      clear_vec = wr.wdata[LINES-1:0];
    end
    if (hit(wr, ADDR_OVF_CLEAR)) begin
      ovf_clear_vec = wr.wdata[LINES-1:0];
    end
  end

  always_comb begin
    next_st = st;
    // flag clears first, then events set it so a same-cycle set wins
    next_st.conversion_irq_flag = st.conversion_irq_flag & ~clear_vec;
    next_st.irq_overflow_flag = st.irq_overflow_flag & ~ovf_clear_vec;
    for (int i = 0; i < LINES; i++) begin
      next_st.irq_pulse[i] = 1'b0;
      if (event_vec[i]) begin
        next_st.conversion_irq_flag[i] = 1'b1;
        if (st.conversion_irq_flag[i]) begin
          next_st.irq_overflow_flag[i] = 1'b1;
        end
        if (st.continuous_irq_select[i] || !st.conversion_irq_flag[i]) begin
          next_st.irq_pulse[i] = 1'b1;
        end
      end
    end
    if (latched.valid) begin
      next_st.conversion_result = latched.data;
    end
    next_st.sts = (st.sts & ~((hit(wr, ADDR_IRQ_STAT)) ? wr.wdata[LINES-1:0] : '0))
      | next_st.irq_pulse;
    if (hit(wr, ADDR_IRQ_MASK)) begin
      next_st.mask = wr.wdata[LINES-1:0];
    end
    if (hit(wr, ADDR_CONT)) begin
      next_st.continuous_irq_select = wr.wdata[LINES-1:0];
    end
    if (hit(wr, ADDR_CTRL)) begin
      next_st.late_mode = wr.wdata[CTRL_LATE_BIT];
      next_st.clock_divider_setting = wr.wdata[CTRL_DIV_LSB +: DIV_W];
    end
    next_st.cpu_irq = |(next_st.sts & next_st.mask);
    next_st.rdata = '0;
    if (rd.sel && !rd.write) begin
      case (rd.addr)
        ADDR_FLAG: next_st.rdata[LINES-1:0] = st.conversion_irq_flag;
        ADDR_OVF: next_st.rdata[LINES-1:0] = st.irq_overflow_flag;
        ADDR_CONT: next_st.rdata[LINES-1:0] = st.continuous_irq_select;
        ADDR_CTRL: begin
          next_st.rdata[CTRL_LATE_BIT] = st.late_mode;
          next_st.rdata[CTRL_DIV_LSB +: DIV_W] = st.clock_divider_setting;
        end
        ADDR_RESULT: next_st.rdata[RESULT_W-1:0] = st.conversion_result;
        ADDR_IRQ_STAT: next_st.rdata[LINES-1:0] = st.sts;
        ADDR_IRQ_MASK: next_st.rdata[LINES-1:0] = st.mask;
        default: next_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // single registered read: the data phase gets one wait state
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      hreadyout_out <= 1'b1;
    end else begin
      hreadyout_out <= !(hready_in && hsel_in && htrans_in == HTRANS_NONSEQ && !hwrite_in);
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      hresp_out <= 1'b0;
    end else begin
      hresp_out <= 1'b0;
    end
  end

  always_comb begin
    hrdata_out = st.rdata;
    conversion_irq_out = st.irq_pulse;
    dma_trigger_out = st.irq_pulse;
    accel_trigger_out = st.irq_pulse;
    conversion_result_out = st.conversion_result;
    cpu_irq_out = st.cpu_irq;
  end

endmodule : aif_irq_ctrl

/* aif_irq_ctrl_props.sv */
`timescale 1ns/1ns
module aif_irq_ctrl_props
  import aif_pkg::*;
#(
  parameter int LINES = NUM_LINES
) (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic hsel_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic hready_in,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input aif_conv_t conv_in,
  input wire logic [LINES-1:0] conversion_irq_out,
  input wire logic [LINES-1:0] dma_trigger_out,
  input wire logic [LINES-1:0] accel_trigger_out,
  input wire logic [RESULT_W-1:0] conversion_result_out
);
  logic taken;
  assign taken = hsel_in && hready_in && htrans_in == HTRANS_NONSEQ && hsize_in == HSIZE_WORD;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  a_read_wait: assert property (taken && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
    else $error("read data phase not one wait cycle");
  a_write_ready: assert property (taken && hwrite_in |=> hreadyout_out)
    else $error("write data phase stalled");
  a_stall_short: assert property (!hreadyout_out |=> hreadyout_out)
    else $error("bus stalled more than one cycle");
  a_resp_okay: assert property (hresp_out == 1'b0)
    else $error("bus response not okay");
  a_triggers_same: assert property (dma_trigger_out == conversion_irq_out &&
    accel_trigger_out == conversion_irq_out) else $error("trigger outputs differ");
  a_pulse_cause: assert property (conversion_irq_out != '0 |-> $past(conv_in.valid) &&
    conversion_irq_out == (LINES'(1) << $past(conv_in.line))) else $error("pulse without event");
  a_pulse_idle: assert property (!conv_in.valid |=> conversion_irq_out == '0)
    else $error("pulse with no event");
  a_result_lag: assert property ($changed(conversion_result_out) |->
    $past(conv_in.valid, 2) || $past(conv_in.valid, 4)) else $error("result latched off time");
endmodule : aif_irq_ctrl_props

/* aif_conv_model.sv */
`timescale 1ns/1ns
module aif_conv_model
  import aif_pkg::*;
(
  input wire logic clock_in,
  output aif_conv_t conv_out
);
  logic busy = 1'b0;
  initial conv_out = '0;
  // data toggles between events so a stale value never looks fresh
  always @(posedge clock_in) begin
    if (!busy) begin
      conv_out.data <= ~conv_out.data;
    end
  end
  task automatic send(input logic [1:0] ln, input logic [RESULT_W-1:0] d);
    busy = 1'b1;
    @(posedge clock_in);
    conv_out <= '{valid: 1'b1, line: ln, data: d};
    @(posedge clock_in);
    conv_out <= '{valid: 1'b0, line: ~ln, data: ~d};
    busy = 1'b0;
  endtask : send
endmodule : aif_conv_model

/* aif_irq_ctrl_tb_top.sv */
`timescale 1ns/1ns
module aif_irq_ctrl_tb_top
  import aif_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] hwdata = '0;
  logic hready;
  logic [31:0] hrdata;
  logic [3:0] irq;
  logic [11:0] result;
  logic cpu_irq;
  aif_conv_t conv;
  int n_errors = 0;
  int total_checks = 0;
  int p;
  int r;
  logic [31:0] x;
  logic [7:0] ctl [3] = '{8'h00, 8'h21, 8'h31};
  int lag [3] = '{1, 1, 3};
  logic [7:0] rst_addr [8] = '{ADDR_FLAG, ADDR_OVF, ADDR_CONT, ADDR_CTRL, ADDR_RESULT,
    ADDR_IRQ_STAT, ADDR_IRQ_MASK, 8'h30};
  always #4 clk = ~clk;
  aif_conv_model conv_model (.clock_in(clk), .conv_out(conv));
  aif_irq_ctrl uut (.clock_in(clk), .srst_in(srst), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hready_in(hready),
    .hwdata_in(hwdata), .hreadyout_out(hready), .hresp_out(), .hrdata_out(hrdata),
    .conv_in(conv), .conversion_irq_out(irq), .dma_trigger_out(), .accel_trigger_out(),
    .conversion_result_out(result), .cpu_irq_out(cpu_irq));
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 50);
    rd = hrdata;
    if (n >= 50) begin
      n_errors++;
      summarize();
    end
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] y;
    bus(1'b1, a, d, y);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] y;
    bus(1'b0, a, 32'h0, y);
    check(y, e);
  endtask : rdchk
  // pulse cycle and result cycle of one event, -1 when absent
  task automatic ev(input logic [1:0] ln, input logic [11:0] d, output int pc, output int rc);
    pc = -1;
    rc = -1;
    conv_model.send(ln, d);
    for (int k = 0; k < 10; k++) begin
      @(negedge clk);
      if (irq[ln] === 1'b1 && pc < 0) pc = k;
      if (result === d && rc < 0) rc = k;
    end
  endtask : ev
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    foreach (rst_addr[i]) rdchk(rst_addr[i], 32'h0);
    $display("test reset values done");
    ev(2'd0, 12'h111, p, r);
    check(p >= 0, 1);
    rdchk(ADDR_FLAG, 32'h1);
    ev(2'd0, 12'h222, p, r);
    check(p, -1);
    rdchk(ADDR_OVF, 32'h1);
    rdchk(ADDR_CLEAR, 32'h0);
    wr(ADDR_CLEAR, 32'h0);
    rdchk(ADDR_FLAG, 32'h1);
    wr(ADDR_CLEAR, 32'h1);
    bus(1'b0, ADDR_OVF, 32'h0, x);
    if (x[0] === 1'b1) wr(ADDR_CLEAR, 32'h1);
    rdchk(ADDR_FLAG, 32'h0);
    wr(ADDR_OVF_CLEAR, 32'h1);
    rdchk(ADDR_OVF, 32'h0);
    ev(2'd0, 12'h333, p, r);
    check(p >= 0, 1);
    $display("test one-shot line done");
    wr(ADDR_CONT, 32'h2);
    repeat (2) begin
      ev(2'd1, 12'h444, p, r);
      check(p >= 0, 1);
    end
    rdchk(ADDR_OVF, 32'h2);
    $display("test continuous line done");
    @(posedge clk);
    fork
      wr(ADDR_CLEAR, 32'h8);
      begin @(posedge clk); conv_model.send(2'd3, 12'h555); end
    join
    bus(1'b0, ADDR_FLAG, 32'h0, x);
    check(x[3], 1'b1);
    $display("test set over clear done");
    foreach (ctl[i]) begin
      wr(ADDR_CTRL, {24'h0, ctl[i]});
      // one-shot line: flag must be clear or no pulse comes
      wr(ADDR_CLEAR, 32'h4);
      ev(2'd2, 12'hA00 + 12'(i), p, r);
      check(r - p, lag[i]);
      rdchk(ADDR_RESULT, 32'hA00 + i);
    end
    $display("test result lag done");
    wr(ADDR_IRQ_STAT, 32'hF);
    wr(ADDR_IRQ_MASK, 32'h2);
    @(negedge clk);
    check(cpu_irq, 1'b0);
    ev(2'd1, 12'h666, p, r);
    check(cpu_irq, 1'b1);
    wr(ADDR_IRQ_STAT, 32'h2);
    @(negedge clk);
    check(cpu_irq, 1'b0);
    wr(ADDR_IRQ_MASK, 32'h0);
    ev(2'd1, 12'h777, p, r);
    check(cpu_irq, 1'b0);
    rdchk(ADDR_IRQ_STAT, 32'h2);
    $display("test cpu interrupt done");
    summarize();
  end
endmodule : aif_irq_ctrl_tb_top
bind aif_irq_ctrl aif_irq_ctrl_props #(.LINES(LINES)) u_props (.clock_in(clock_in),
  .srst_in(srst_in), .hsel_in(hsel_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
  .hsize_in(hsize_in), .hready_in(hready_in), .hreadyout_out(hreadyout_out),
  .hresp_out(hresp_out), .conv_in(conv_in), .conversion_irq_out(conversion_irq_out),
  .dma_trigger_out(dma_trigger_out), .accel_trigger_out(accel_trigger_out),
  .conversion_result_out(conversion_result_out));
